// File: src/cmx_pkg.sv
package cmx_pkg;

   // special function register addresses
   localparam logic [7:0] CMX_ADDR_INPUT_SEL = 8'h9E;
   localparam logic [7:0] CMX_ADDR_MODE_SEL = 8'h9C;
   localparam logic [7:0] CMX_ADDR_CMP_CTRL = 8'h9A;
   localparam logic [7:0] CMX_ADDR_REG_CTRL = 8'hC9;

   // reset values
   localparam logic [7:0] CMX_RST_INPUT_SEL = 8'h00;
   localparam logic [7:0] CMX_RST_MODE_SEL = 8'h02;
   localparam logic [7:0] CMX_RST_REG_CTRL = 8'h00;

   // field positions
   localparam int CMX_NEG_LSB = 4;
   localparam int CMX_POS_LSB = 0;
   localparam int CMX_RISE_EN_BIT = 5;
   localparam int CMX_FALL_EN_BIT = 4;
   localparam int CMX_MODE_LSB = 0;
   localparam int CMX_RISE_FLAG_BIT = 5;
   localparam int CMX_FALL_FLAG_BIT = 4;
   localparam int CMX_OUT_BIT = 6;
   localparam int CMX_REG_DIS_BIT = 7;

   // writable bit masks
   localparam logic [7:0] CMX_MASK_INPUT_SEL = 8'h77;
   localparam logic [7:0] CMX_MASK_MODE_SEL = 8'h33;
   localparam logic [7:0] CMX_MASK_REG_CTRL = 8'h80;

   // highest defined selector code
   localparam logic [2:0] CMX_SEL_MAX = 3'h4;

   // special function register access
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cmx_sfr_req_t;

   // routing towards the analog macro
   typedef struct packed {
      logic [4:0] neg_onehot;
      logic [4:0] pos_onehot;
      logic [1:0] speed_power_mode;
      logic regulator_on;
      logic irq;
   } cmx_analog_t;

   // port pad picked by a selector code; valid low for reserved codes
   typedef struct packed {
      logic valid;
      logic [2:0] port_num;
      logic [2:0] bit_num;
   } cmx_pad_t;

endpackage : cmx_pkg

// File: src/cmx_edge_flags.sv
`timescale 1ns/100ps
// rising and falling flags on the comparator output, set wins over clear
module cmx_edge_flags
   import cmx_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic cmp_out_async,
   input wire logic clr_rise,
   input wire logic clr_fall,
   output logic cmp_level,
   output logic cmp1_rise_flag,
   output logic cmp1_fall_flag
);

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic prev;
      logic rise;
      logic fall;
      logic [2:0] fill;
   } cmx_edge_state_t;

   cmx_edge_state_t state_q;
   cmx_edge_state_t state_d;

   // edge detect on synchronised level only
   always_comb
   begin
      state_d = state_q;
      state_d.sync1 = cmp_out_async;
      state_d.sync2 = state_q.sync1;
      state_d.prev = state_q.sync2;
      state_d.fill = {state_q.fill[1:0], 1'b1}; // no edge until prev holds a real sample
      state_d.rise = (state_q.rise & ~clr_rise) | (state_q.fill[2] & state_q.sync2 & ~state_q.prev);
      state_d.fall = (state_q.fall & ~clr_fall) | (state_q.fill[2] & ~state_q.sync2 & state_q.prev);
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         state_q <= '0;
      else
         state_q <= state_d;
   end

   assign cmp_level = state_q.sync2;
   assign cmp1_rise_flag = state_q.rise;
   assign cmp1_fall_flag = state_q.fall;

endmodule : cmx_edge_flags

// File: src/cmx_comparator1_cfg.sv
`timescale 1ns/100ps
module cmx_comparator1_cfg
   import cmx_pkg::*;
#(
   parameter bit LARGE_PACKAGE = 1'b0
)
(
   input wire logic clk,
   input wire logic srst,
   input cmx_sfr_req_t sfr_req,
   input wire logic cmp_out_async,
   output logic [7:0] sfr_rdata,
   output logic [4:0] neg_pin_onehot,
   output logic [4:0] pos_pin_onehot,
   output cmx_pad_t neg_pad,
   output cmx_pad_t pos_pad,
   output logic [1:0] cmp1_speed_power_mode,
   output logic regulator_on,
   output logic cmp1_irq
);

   typedef struct packed {
      logic [7:0] input_sel;
      logic [7:0] mode_sel;
      logic reg_dis;
      logic [7:0] rdata;
      logic [4:0] neg_oh;
      logic [4:0] pos_oh;
      cmx_pad_t neg_pad;
      cmx_pad_t pos_pad;
      logic [1:0] mode;
      logic reg_on;
      logic irq;
   } cmx_state_t;

   // all state of the bank in one struct, except the synchroniser and edge flags held in u_edge
   cmx_state_t state_q;
   cmx_state_t state_d;
   logic cmp_level;
   logic rise_flag;
   logic fall_flag;
   logic clr_rise;
   logic clr_fall;

   // selector code to one-hot pin index; reserved codes select nothing
   function automatic logic [4:0] sel_decode(input logic [2:0] code);
      logic [4:0] oh;
      oh = 5'h00;
      if (code <= CMX_SEL_MAX)
         oh[code] = 1'b1;
      return oh;
   endfunction : sel_decode

   // selector code to port pad of the fitted package; reserved codes give no pad
   function automatic cmx_pad_t pad_map(input logic neg_side, input logic [2:0] code);
      cmx_pad_t pad;
      logic [5:0] id;
      id = 6'h00;
      if (neg_side)
      begin
         if (LARGE_PACKAGE)
         begin
            // larger package, negative input
            unique case (code)
               3'h0: id = 6'h13; // port 2 pin 3
               3'h1: id = 6'h19; // port 3 pin 1
               3'h2: id = 6'h20; // port 4 pin 0
               3'h3: id = 6'h26; // port 4 pin 6
               3'h4: id = 6'h0A; // port 1 pin 2
               default: id = 6'h00;
            endcase
         end
         else
         begin
            // smaller package, negative input
            unique case (code)
               3'h0: id = 6'h0B; // port 1 pin 3
               3'h1: id = 6'h0F; // port 1 pin 7
               3'h2: id = 6'h13; // port 2 pin 3
               3'h3: id = 6'h17; // port 2 pin 7
               3'h4: id = 6'h05; // port 0 pin 5
               default: id = 6'h00;
            endcase
         end
      end
      else
      begin
         if (LARGE_PACKAGE)
         begin
            // larger package, positive input
            unique case (code)
               3'h0: id = 6'h12; // port 2 pin 2
               3'h1: id = 6'h18; // port 3 pin 0
               3'h2: id = 6'h1F; // port 3 pin 7
               3'h3: id = 6'h25; // port 4 pin 5
               3'h4: id = 6'h09; // port 1 pin 1
               default: id = 6'h00;
            endcase
         end
         else
         begin
            // smaller package, positive input
            unique case (code)
               3'h0: id = 6'h0A; // port 1 pin 2
               3'h1: id = 6'h0E; // port 1 pin 6
               3'h2: id = 6'h12; // port 2 pin 2
               3'h3: id = 6'h16; // port 2 pin 6
               3'h4: id = 6'h04; // port 0 pin 4
               default: id = 6'h00;
            endcase
         end
      end
      pad.valid = (code <= CMX_SEL_MAX);
      pad.port_num = id[5:3];
      pad.bit_num = id[2:0];
      return pad;
   endfunction : pad_map

   // flags live in the control register; writing zero clears them
   assign clr_rise = sfr_req.wr && sfr_req.addr == CMX_ADDR_CMP_CTRL && !sfr_req.wdata[CMX_RISE_FLAG_BIT];
   assign clr_fall = sfr_req.wr && sfr_req.addr == CMX_ADDR_CMP_CTRL && !sfr_req.wdata[CMX_FALL_FLAG_BIT];

   // synchroniser and sticky edge flags
   cmx_edge_flags u_edge (
      .clk(clk),
      .srst(srst),
      .cmp_out_async(cmp_out_async),
      .clr_rise(clr_rise),
      .clr_fall(clr_fall),
      .cmp_level(cmp_level),
      .cmp1_rise_flag(rise_flag),
      .cmp1_fall_flag(fall_flag)
   );

   // register writes, read mux and derived outputs
   always_comb
   begin
      state_d = state_q;
      // register writes, spare bits masked off
      if (sfr_req.wr)
      begin
         unique case (sfr_req.addr)
            CMX_ADDR_INPUT_SEL: state_d.input_sel = sfr_req.wdata & CMX_MASK_INPUT_SEL;
            CMX_ADDR_MODE_SEL: state_d.mode_sel = sfr_req.wdata & CMX_MASK_MODE_SEL;
            CMX_ADDR_REG_CTRL: state_d.reg_dis = sfr_req.wdata[CMX_REG_DIS_BIT];
            default: ;
         endcase
      end

      // read mux, zero when no read
      state_d.rdata = 8'h00;
      if (sfr_req.rd)
      begin
         unique case (sfr_req.addr)
            CMX_ADDR_INPUT_SEL: state_d.rdata = state_q.input_sel;
            CMX_ADDR_MODE_SEL: state_d.rdata = state_q.mode_sel;
            CMX_ADDR_REG_CTRL: state_d.rdata = {state_q.reg_dis, 7'h00};
            CMX_ADDR_CMP_CTRL:
            begin
               state_d.rdata[CMX_OUT_BIT] = cmp_level;
               state_d.rdata[CMX_RISE_FLAG_BIT] = rise_flag;
               state_d.rdata[CMX_FALL_FLAG_BIT] = fall_flag;
            end
            default: state_d.rdata = 8'h00;
         endcase
      end

      // routing follows the new register value; pad map depends on the package
      state_d.neg_oh = sel_decode(state_d.input_sel[CMX_NEG_LSB +: 3]);
      state_d.pos_oh = sel_decode(state_d.input_sel[CMX_POS_LSB +: 3]);
      state_d.neg_pad = pad_map(1'b1, state_d.input_sel[CMX_NEG_LSB +: 3]);
      state_d.pos_pad = pad_map(1'b0, state_d.input_sel[CMX_POS_LSB +: 3]);
      state_d.mode = state_d.mode_sel[CMX_MODE_LSB +: 2];
      state_d.reg_on = ~state_d.reg_dis;
      state_d.irq = (rise_flag & state_d.mode_sel[CMX_RISE_EN_BIT])
                  | (fall_flag & state_d.mode_sel[CMX_FALL_EN_BIT]);
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_q <= '0;
         state_q.input_sel <= CMX_RST_INPUT_SEL;
         state_q.mode_sel <= CMX_RST_MODE_SEL;
         state_q.reg_dis <= CMX_RST_REG_CTRL[CMX_REG_DIS_BIT];
         state_q.neg_oh <= sel_decode(CMX_RST_INPUT_SEL[CMX_NEG_LSB +: 3]);
         state_q.pos_oh <= sel_decode(CMX_RST_INPUT_SEL[CMX_POS_LSB +: 3]);
         state_q.neg_pad <= pad_map(1'b1, CMX_RST_INPUT_SEL[CMX_NEG_LSB +: 3]);
         state_q.pos_pad <= pad_map(1'b0, CMX_RST_INPUT_SEL[CMX_POS_LSB +: 3]);
         state_q.mode <= CMX_RST_MODE_SEL[1:0];
         state_q.reg_on <= 1'b1;
      end
      else
         state_q <= state_d;
   end

   // every output straight from the state register
   assign sfr_rdata = state_q.rdata;
   assign neg_pin_onehot = state_q.neg_oh;
   assign pos_pin_onehot = state_q.pos_oh;
   assign neg_pad = state_q.neg_pad;
   assign pos_pad = state_q.pos_pad;
   assign cmp1_speed_power_mode = state_q.mode;
   assign regulator_on = state_q.reg_on;
   assign cmp1_irq = state_q.irq;

endmodule : cmx_comparator1_cfg

// File: bench/cmx_cfg_props.sv
`timescale 1ns/100ps
// port-level checks of the register bank
module cmx_cfg_props
   import cmx_pkg::*;
(
   input logic clk,
   input logic srst,
   input cmx_sfr_req_t sfr_req,
   input logic [7:0] sfr_rdata,
   input logic [4:0] neg_pin_onehot,
   input logic [4:0] pos_pin_onehot,
   input logic [1:0] cmp1_speed_power_mode,
   input logic regulator_on
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // decoded requests
   logic w_sel, w_mode, w_reg;
   assign w_sel = sfr_req.wr && sfr_req.addr == CMX_ADDR_INPUT_SEL;
   assign w_mode = sfr_req.wr && sfr_req.addr == CMX_ADDR_MODE_SEL;
   assign w_reg = sfr_req.wr && sfr_req.addr == CMX_ADDR_REG_CTRL;
   rdata_idle_a: assert property (!$past(sfr_req.rd) |-> sfr_rdata == 8'h00)
      else $error("read data not idle");
   neg_route_a: assert property (w_sel |=> neg_pin_onehot == 5'(5'h01 << $past(sfr_req.wdata[6:4])))
      else $error("negative route wrong");
   pos_route_a: assert property (w_sel |=> pos_pin_onehot == 5'(5'h01 << $past(sfr_req.wdata[2:0])))
      else $error("positive route wrong");
   mode_write_a: assert property (w_mode |=> cmp1_speed_power_mode == $past(sfr_req.wdata[1:0]))
      else $error("mode not taken");
   reg_write_a: assert property (w_reg |=> regulator_on == !$past(sfr_req.wdata[7]))
      else $error("regulator not taken");
   sel_spare_a: assert property (sfr_req.rd && sfr_req.addr == CMX_ADDR_INPUT_SEL |=> !(|(sfr_rdata & 8'h88)))
      else $error("select spare bits set");
   mode_spare_a: assert property (sfr_req.rd && sfr_req.addr == CMX_ADDR_MODE_SEL |=> !(|(sfr_rdata & 8'hCC)))
      else $error("mode spare bits set");
   cfg_hold_a: assert property (!sfr_req.wr |=> $stable({neg_pin_onehot, pos_pin_onehot, regulator_on}))
      else $error("config changed without write");
endmodule : cmx_cfg_props

bind cmx_comparator1_cfg cmx_cfg_props u_props (.clk(clk), .srst(srst), .sfr_req(sfr_req),
   .sfr_rdata(sfr_rdata), .neg_pin_onehot(neg_pin_onehot), .pos_pin_onehot(pos_pin_onehot),
   .cmp1_speed_power_mode(cmp1_speed_power_mode), .regulator_on(regulator_on));

// File: bench/cmx_comparator1_cfg_tb.sv
`timescale 1ns/100ps
module cmx_comparator1_cfg_tb;
   import cmx_pkg::*;
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
   $display("unexpected at %0t: got %h", $time, (a)); end end
   logic clk = 0, srst = 1, cmp_in = 0, reg_on, irq;
   cmx_sfr_req_t req = '0;
   logic [7:0] rdata;
   logic [4:0] neg_oh, pos_oh;
   logic [1:0] mode;
   cmx_pad_t neg_pad, pos_pad, neg_pad_l, pos_pad_l;
   // expected pads per code, {port, pin}, code 0 in the low six bits
   localparam logic [29:0] PAD_NEG_SMALL = {6'h05, 6'h17, 6'h13, 6'h0F, 6'h0B};
   localparam logic [29:0] PAD_NEG_LARGE = {6'h0A, 6'h26, 6'h20, 6'h19, 6'h13};
   localparam logic [29:0] PAD_POS_SMALL = {6'h04, 6'h16, 6'h12, 6'h0E, 6'h0A};
   localparam logic [29:0] PAD_POS_LARGE = {6'h09, 6'h25, 6'h1F, 6'h18, 6'h12};
   int num_errors = 0, samples_checked = 0;
   always #5 clk = ~clk;
   cmx_comparator1_cfg DUT (.clk(clk), .srst(srst), .sfr_req(req), .cmp_out_async(cmp_in), .sfr_rdata(rdata),
      .neg_pin_onehot(neg_oh), .pos_pin_onehot(pos_oh), .neg_pad(neg_pad), .pos_pad(pos_pad),
      .cmp1_speed_power_mode(mode), .regulator_on(reg_on), .cmp1_irq(irq));
   // larger package variant, only its pad map is judged
   cmx_comparator1_cfg #(.LARGE_PACKAGE(1'b1)) DUT_LARGE (.clk(clk), .srst(srst), .sfr_req(req),
      .cmp_out_async(cmp_in), .sfr_rdata(), .neg_pin_onehot(), .pos_pin_onehot(), .neg_pad(neg_pad_l),
      .pos_pad(pos_pad_l), .cmp1_speed_power_mode(), .regulator_on(), .cmp1_irq());
   // one register access, read data valid on return
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      req = '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clk);
      #1;
      req = '0;
   endtask : acc
   task automatic t_sel();
      for (int c = 0; c < 8; c++)
      begin
         acc(1, CMX_ADDR_INPUT_SEL, {1'b1, 3'(c), 1'b1, 3'(7 - c)});
         `CHK(neg_oh, (c < 5) ? 5'(5'h01 << c) : 5'h00)
         `CHK(pos_oh, (c > 2) ? 5'(5'h01 << (7 - c)) : 5'h00)
         `CHK(neg_pad, (c < 5) ? {1'b1, PAD_NEG_SMALL[6 * c +: 6]} : 7'h00)
         `CHK(neg_pad_l, (c < 5) ? {1'b1, PAD_NEG_LARGE[6 * c +: 6]} : 7'h00)
         `CHK(pos_pad, (c > 2) ? {1'b1, PAD_POS_SMALL[6 * (7 - c) +: 6]} : 7'h00)
         `CHK(pos_pad_l, (c > 2) ? {1'b1, PAD_POS_LARGE[6 * (7 - c) +: 6]} : 7'h00)
         acc(0, CMX_ADDR_INPUT_SEL, 8'h00);
         `CHK(rdata, {1'b0, 3'(c), 1'b0, 3'(7 - c)})
      end
   endtask : t_sel
   task automatic t_mode();
      for (int m = 0; m < 4; m++)
      begin
         acc(1, CMX_ADDR_MODE_SEL, 8'hCC | 8'(m));
         `CHK(mode, 2'(m))
         acc(0, CMX_ADDR_MODE_SEL, 8'h00);
         `CHK(rdata, 8'(m))
      end
   endtask : t_mode
   // edge on the comparator, wrong enable first, then the right one
   task automatic t_edge(input logic lvl, input logic [7:0] en);
      cmp_in = lvl;
      acc(1, CMX_ADDR_MODE_SEL, en ^ 8'h30);
      repeat (6) @(posedge clk);
      #1;
      `CHK(irq, 1'b0)
      acc(0, CMX_ADDR_CMP_CTRL, 8'h00);
      `CHK(rdata & 8'h70, en | {1'b0, lvl, 6'h00})
      acc(1, CMX_ADDR_MODE_SEL, en);
      repeat (2) @(posedge clk);
      #1;
      `CHK(irq, 1'b1)
      acc(1, CMX_ADDR_CMP_CTRL, 8'h00);
      repeat (2) @(posedge clk);
      #1;
      `CHK(irq, 1'b0)
   endtask : t_edge
   task automatic t_misc();
      `CHK({neg_oh, pos_oh, mode, reg_on, irq}, 14'h021A)
      `CHK({neg_pad, pos_pad}, {1'b1, PAD_NEG_SMALL[5:0], 1'b1, PAD_POS_SMALL[5:0]})
      acc(0, CMX_ADDR_MODE_SEL, 8'h00);
      `CHK(rdata, 8'h02)
      acc(1, CMX_ADDR_REG_CTRL, 8'h80);
      `CHK(reg_on, 1'b0)
      acc(1, 8'h11, 8'h55);
      acc(0, 8'h11, 8'h00);
      `CHK(rdata, 8'h00)
   endtask : t_misc
   task automatic end_sim();
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim
   // main sequence
   initial
   begin
      repeat (3) @(posedge clk);
      #1;
      srst = 0;
      t_misc();
      t_sel();
      t_mode();
      t_edge(1'b1, 8'h20);
      t_edge(1'b0, 8'h10);
      end_sim();
   end
   // watchdog
   initial
   begin
      repeat (2000) @(posedge clk);
      num_errors++;
      end_sim();
   end
endmodule : cmx_comparator1_cfg_tb
